/* File: src/apgpi_top.sv */
// General-purpose I/O port shared with analog inputs, with edge pin interrupts.
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RULE1: A general-purpose output pin drives its port data register bit.
// RULE2: Data register reads return the stored bit where direction is output.
// RULE3: Input pins with digital input enabled read their synchronised level instead.
// RULE4: Input register returns synchronised level if enabled, otherwise logic one.
// RULE5: Input register is always readable; writes to it change nothing.
// RULE6: Direction bits five to zero: one means output, zero means input.
// RULE7: Digital input path works only while its digital input enable is one.
// RULE8: Pull enable activates the pull device on inputs only, never on outputs.
// RULE9: Polarity one selects pulldown and rising edge; zero pullup and falling edge.
// RULE10: Interrupt enable one lets a flag raise interrupt; zero masks it.
// RULE11: Edge detection works for input and output pins alike.
// RULE12: Enabled active edge requests the RC oscillator to wake from stop.
// RULE13: Data register at 0x0271, resets to zero, upper two bits read zero.
// RULE14: Pins not claimed by the analog function are usable as general I/O.
// RULE15: Flag sets on active edge; writing one clears, zero leaves it.
// RULE16: Reads may lag a direction change by at most two bus cycles.
// RULE17: Pins pass a two-stage synchroniser; interrupt is OR of enabled flags.
module apgpi_top #(
  parameter int unsigned PIN_COUNT = apgpi_pkg::PIN_COUNT
) (
  // Clock and reset.
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  // Register bus.
  input wire logic [apgpi_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [apgpi_pkg::REG_W-1:0] I_WR_DATA,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  output logic [apgpi_pkg::REG_W-1:0] O_RD_DATA,
  // Neighbouring converter and power control.
  input wire logic [PIN_COUNT-1:0] I_DIG_IN_EN,
  input wire logic [PIN_COUNT-1:0] I_ANALOG_SEL,
  input wire logic I_STOP_MODE,
  output logic O_OSC_WAKE_REQ,
  // Port pins.
  input wire logic [PIN_COUNT-1:0] I_PIN,
  output logic [PIN_COUNT-1:0] O_PIN,
  output logic [PIN_COUNT-1:0] O_PIN_OE,
  output logic [PIN_COUNT-1:0] O_PULL_UP_EN,
  output logic [PIN_COUNT-1:0] O_PULL_DOWN_EN,
  // Interrupt.
  output logic O_IRQ
);

  localparam int unsigned RW = apgpi_pkg::REG_W;

  // A pin count outside one register's width cannot be served by the read mux.
  if (PIN_COUNT < 1 || PIN_COUNT > RW) begin : g_bad_pin_count
    $error("PIN_COUNT must lie between 1 and the register width.");
  end

  // Software-visible state.
  logic [PIN_COUNT-1:0] port_output_data;
  logic [PIN_COUNT-1:0] pin_direction;
  logic [PIN_COUNT-1:0] pull_device_enable;
  logic [PIN_COUNT-1:0] pull_and_edge_polarity;
  logic [PIN_COUNT-1:0] pin_irq_enable;
  logic [PIN_COUNT-1:0] pin_irq_flag;

  // Pin sampling.
  logic [PIN_COUNT-1:0] pin_meta;
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev;

  // Combinational terms.
  logic [PIN_COUNT-1:0] pin_level_input;
  logic [PIN_COUNT-1:0] data_view;
  logic [PIN_COUNT-1:0] active_edge;
  logic [PIN_COUNT-1:0] flag_clear;
  logic [PIN_COUNT-1:0] next_pin_irq_flag;
  logic [RW-1:0] next_rd_data;

  // Widens a pin vector to the register width, upper bits reading zero.
  function automatic logic [RW-1:0] widen(input logic [PIN_COUNT-1:0] v);
    logic [RW-1:0] r;
    r = '0;
    r[PIN_COUNT-1:0] = v;
    return r;
  endfunction : widen

  // Level seen through the digital input path of each pin.
  function automatic logic [PIN_COUNT-1:0] gated_level(
    input logic [PIN_COUNT-1:0] lvl,
    input logic [PIN_COUNT-1:0] en
  );
    logic [PIN_COUNT-1:0] r;
    r = '0;
    for (int i = 0; i < PIN_COUNT; i++) begin
      r[i] = en[i] ? lvl[i] : apgpi_pkg::DISABLED_LEVEL;
    end
    return r;
  endfunction : gated_level

  function automatic logic hit(input logic [apgpi_pkg::ADDR_W-1:0] a);
    return I_WR_EN && (I_ADDR == a);
  endfunction : hit

  // RULE17: two-stage synchroniser
  // Edges are judged on the second stage and its delayed copy pin_prev, so a metastable first stage never reaches logic.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= I_PIN;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // RULE13: data register storage
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      port_output_data <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
    end else if (hit(apgpi_pkg::ADDR_PORT_OUTPUT_DATA)) begin
      port_output_data <= I_WR_DATA[PIN_COUNT-1:0];
    end
  end

  // RULE6: direction register
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_direction <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
    end else if (hit(apgpi_pkg::ADDR_PIN_DIRECTION)) begin
      pin_direction <= I_WR_DATA[PIN_COUNT-1:0];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pull_device_enable <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
      pull_and_edge_polarity <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
      pin_irq_enable <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
    end else begin
      if (hit(apgpi_pkg::ADDR_PULL_DEVICE_ENABLE)) begin
        pull_device_enable <= I_WR_DATA[PIN_COUNT-1:0];
      end
      if (hit(apgpi_pkg::ADDR_PULL_AND_EDGE_POLARITY)) begin
        pull_and_edge_polarity <= I_WR_DATA[PIN_COUNT-1:0];
      end
      if (hit(apgpi_pkg::ADDR_PIN_IRQ_ENABLE)) begin
        pin_irq_enable <= I_WR_DATA[PIN_COUNT-1:0];
      end
    end
  end

  always_comb begin
    // RULE7: input path gated by enable
    // RULE4: disabled input reads one
    pin_level_input = gated_level(pin_sync, I_DIG_IN_EN);
    // RULE2: outputs read stored bit
    // RULE3: inputs read synchronised level
    // RULE16: two-cycle read lag
    data_view = (pin_direction & port_output_data) | (~pin_direction & pin_level_input);
  end

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      // RULE9: polarity picks edge
      // RULE11: edges seen in either direction
      if (pull_and_edge_polarity[i] == apgpi_pkg::POL_RISING_PULLDOWN) begin
        active_edge[i] = I_DIG_IN_EN[i] && pin_sync[i] && !pin_prev[i];
      end else begin
        active_edge[i] = I_DIG_IN_EN[i] && !pin_sync[i] && pin_prev[i];
      end
    end
  end

  always_comb begin
    flag_clear = '0;
    if (hit(apgpi_pkg::ADDR_PIN_IRQ_FLAG) || hit(apgpi_pkg::ADDR_PIN_IRQ_CLEAR)) begin
      flag_clear = I_WR_DATA[PIN_COUNT-1:0];
    end
    // RULE15: set beats write-one clear
    // A clear landing on the same edge as a new event must not lose the event.
    next_pin_irq_flag = (pin_irq_flag & ~flag_clear) | active_edge;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      pin_irq_flag <= apgpi_pkg::RST_REG[PIN_COUNT-1:0];
    end else begin
      pin_irq_flag <= next_pin_irq_flag;
    end
  end

  // RULE5: input register write ignored
  // No write decode exists for the input register address; it only appears in the read mux.
  always_comb begin
    next_rd_data = apgpi_pkg::RD_IDLE;
    if (I_RD_EN) begin
      case (I_ADDR)
        apgpi_pkg::ADDR_PORT_OUTPUT_DATA: next_rd_data = widen(data_view);
        apgpi_pkg::ADDR_PIN_LEVEL_INPUT: next_rd_data = widen(pin_level_input);
        apgpi_pkg::ADDR_PIN_DIRECTION: next_rd_data = widen(pin_direction);
        apgpi_pkg::ADDR_PULL_DEVICE_ENABLE: next_rd_data = widen(pull_device_enable);
        apgpi_pkg::ADDR_PULL_AND_EDGE_POLARITY: next_rd_data = widen(pull_and_edge_polarity);
        apgpi_pkg::ADDR_PIN_IRQ_ENABLE: next_rd_data = widen(pin_irq_enable);
        apgpi_pkg::ADDR_PIN_IRQ_FLAG: next_rd_data = widen(pin_irq_flag);
        default: next_rd_data = apgpi_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_RD_DATA <= apgpi_pkg::RD_IDLE;
    end else begin
      O_RD_DATA <= next_rd_data;
    end
  end

  // Pin drivers; registered so every pin output changes one edge after its cause.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PIN <= '0;
      O_PIN_OE <= '0;
      O_PULL_UP_EN <= '0;
      O_PULL_DOWN_EN <= '0;
    end else begin
      // RULE1: drive data bit
      O_PIN <= port_output_data;
      // RULE14: analog use releases pin
      O_PIN_OE <= pin_direction & ~I_ANALOG_SEL;
      // RULE8: pulls only on inputs
      O_PULL_UP_EN <= pull_device_enable & ~pin_direction & ~pull_and_edge_polarity;
      O_PULL_DOWN_EN <= pull_device_enable & ~pin_direction & pull_and_edge_polarity;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_IRQ <= 1'b0;
      O_OSC_WAKE_REQ <= 1'b0;
    end else begin
      // RULE10: mask flags
      // RULE17: OR of enabled flags
      O_IRQ <= |(pin_irq_flag & pin_irq_enable);
      // RULE12: wake request in stop
      O_OSC_WAKE_REQ <= I_STOP_MODE && |(pin_irq_flag & pin_irq_enable);
    end
  end

endmodule : apgpi_top
`default_nettype wire

/* File: pkg/apgpi_pkg.sv */
// Constants shared by the analog-port general-purpose I/O block.
`default_nettype none
package apgpi_pkg;

  // Register bus widths.
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned REG_W = 8;

  // Documented pin count of the port.
  localparam int unsigned PIN_COUNT = 6;

  // Register addresses.
  localparam logic [ADDR_W-1:0] ADDR_PORT_OUTPUT_DATA = 16'h0271;
  localparam logic [ADDR_W-1:0] ADDR_PIN_LEVEL_INPUT = 16'h0273;
  localparam logic [ADDR_W-1:0] ADDR_PIN_DIRECTION = 16'h0275;
  localparam logic [ADDR_W-1:0] ADDR_PULL_DEVICE_ENABLE = 16'h0277;
  localparam logic [ADDR_W-1:0] ADDR_PULL_AND_EDGE_POLARITY = 16'h0279;
  localparam logic [ADDR_W-1:0] ADDR_PIN_IRQ_ENABLE = 16'h027b;
  localparam logic [ADDR_W-1:0] ADDR_PIN_IRQ_FLAG = 16'h027d;
  localparam logic [ADDR_W-1:0] ADDR_PIN_IRQ_CLEAR = 16'h027f;

  // Reset values.
  localparam logic [REG_W-1:0] RST_REG = 8'h00;
  localparam logic [REG_W-1:0] RD_IDLE = 8'h00;

  // Level a disabled digital input path reads as.
  localparam logic DISABLED_LEVEL = 1'b1;

  // Polarity bit encodings.
  localparam logic POL_RISING_PULLDOWN = 1'b1;

  // Synchroniser depth on pin levels.
  localparam int unsigned SYNC_STAGES = 2;

endpackage : apgpi_pkg
`default_nettype wire

/* File: bench/apgpi_checker.sv */
// Port-level assertions for the analog-port I/O block.
`timescale 1ns/1ps
`default_nettype none
module apgpi_checker #(
  parameter int unsigned PIN_COUNT = 6
) (
  // Clock, reset and bus.
  input wire logic I_MCLK,
  input wire logic I_RST_N,
  input wire logic [15:0] I_ADDR,
  input wire logic [7:0] I_WR_DATA,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [7:0] O_RD_DATA,
  // Side controls and pins.
  input wire logic [PIN_COUNT-1:0] I_DIG_IN_EN,
  input wire logic [PIN_COUNT-1:0] I_ANALOG_SEL,
  input wire logic O_OSC_WAKE_REQ,
  input wire logic [PIN_COUNT-1:0] O_PIN,
  input wire logic [PIN_COUNT-1:0] O_PIN_OE,
  input wire logic [PIN_COUNT-1:0] O_PULL_UP_EN,
  input wire logic [PIN_COUNT-1:0] O_PULL_DOWN_EN,
  input wire logic O_IRQ
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  pin_drive_a: assert property (I_WR_EN && I_ADDR == apgpi_pkg::ADDR_PORT_OUTPUT_DATA
    |-> ##2 O_PIN == $past(I_WR_DATA[PIN_COUNT-1:0], 2)) else $error("pin level wrong");
  input_dis_a: assert property (I_RD_EN && I_ADDR == apgpi_pkg::ADDR_PIN_LEVEL_INPUT
    |=> &(O_RD_DATA[PIN_COUNT-1:0] | $past(I_DIG_IN_EN))) else $error("disabled input not one");
  rd_idle_a: assert property (!$past(I_RD_EN) |-> O_RD_DATA == 8'h00)
    else $error("read data not idle");
  upper_zero_a: assert property (O_RD_DATA[7:6] == 2'h0) else $error("upper bits set");
  pull_excl_a: assert property ((O_PULL_UP_EN & O_PULL_DOWN_EN) == '0)
    else $error("both pulls on");
  pull_out_a: assert property (((O_PULL_UP_EN | O_PULL_DOWN_EN) & O_PIN_OE) == '0)
    else $error("pull on driven pin");
  analog_oe_a: assert property ((O_PIN_OE & $past(I_ANALOG_SEL)) == '0)
    else $error("analog pin driven");
  wake_irq_a: assert property (O_OSC_WAKE_REQ |-> O_IRQ) else $error("wake without irq");
  irq_fall_a: assert property ($fell(O_IRQ) |-> $past(I_WR_EN, 2))
    else $error("irq dropped unasked");
  cover property (O_IRQ);
  cover property (O_OSC_WAKE_REQ);
  cover property (O_PULL_DOWN_EN != '0);
endmodule : apgpi_checker
bind apgpi_top apgpi_checker #(.PIN_COUNT(PIN_COUNT)) i_chk (.*);
`default_nettype wire

/* File: bench/apgpi_pins_model.sv */
// Behavioural model of the circuitry on the six port pins.
`timescale 1ns/1ps
`default_nettype none
module apgpi_pins_model (
  // Block side.
  input wire logic i_clk,
  input wire logic [5:0] i_pin_out,
  input wire logic [5:0] i_pin_oe,
  input wire logic [5:0] i_pull_up,
  input wire logic [5:0] i_pull_down,
  // Bench commands.
  input wire logic [5:0] i_drv_en,
  input wire logic [5:0] i_drv_val,
  // Wire level.
  output logic [5:0] o_level
);
  logic flip = 1'b0;
  // A floating pin toggles so that a stale value can never pass for a real one.
  always @(posedge i_clk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (i_pin_oe[i]) o_level[i] = i_pin_out[i];
      else if (i_drv_en[i]) o_level[i] = i_drv_val[i];
      else if (i_pull_up[i]) o_level[i] = 1'b1;
      else if (i_pull_down[i]) o_level[i] = 1'b0;
      else o_level[i] = flip;
    end
  end
endmodule : apgpi_pins_model
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the analog-port I/O block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic I_MCLK = 1'b0;
  logic I_RST_N = 1'b0;
  logic [15:0] I_ADDR = 16'h0000;
  logic [7:0] I_WR_DATA = 8'h00;
  logic I_WR_EN = 1'b0;
  logic I_RD_EN = 1'b0;
  logic I_STOP_MODE = 1'b0;
  logic [5:0] I_DIG_IN_EN = 6'h00;
  logic [5:0] I_ANALOG_SEL = 6'h00;
  logic [5:0] drv_en = 6'h3f;
  logic [5:0] drv_val = 6'h00;
  logic [5:0] I_PIN, O_PIN, O_PIN_OE, O_PULL_UP_EN, O_PULL_DOWN_EN;
  logic [7:0] O_RD_DATA;
  logic O_OSC_WAKE_REQ, O_IRQ;
  int failures = 0;
  int num_checks = 0;
  apgpi_top i_dut (.*);
  apgpi_pins_model i_pins (.i_clk(I_MCLK), .i_pin_out(O_PIN), .i_pin_oe(O_PIN_OE),
    .i_pull_up(O_PULL_UP_EN), .i_pull_down(O_PULL_DOWN_EN), .i_drv_en(drv_en),
    .i_drv_val(drv_val), .o_level(I_PIN));
  initial forever #5 I_MCLK = ~I_MCLK;
  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask : cyc
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_WR_DATA <= d;
    I_WR_EN <= 1'b1;
    @(posedge I_MCLK);
    I_WR_EN <= 1'b0;
  endtask : wr
  task automatic rd(logic [15:0] a, logic [7:0] e);
    @(posedge I_MCLK);
    I_ADDR <= a;
    I_RD_EN <= 1'b1;
    @(posedge I_MCLK);
    I_RD_EN <= 1'b0;
    #1;
    chk($sformatf("read %h", a), O_RD_DATA, e);
  endtask : rd
  // The bound covers the two sync stages plus flag and interrupt registers.
  task automatic wait_irq();
    for (int k = 0; k < 8; k++) begin
      cyc(1);
      if (O_IRQ === 1'b1) return;
    end
    failures++;
    complete_run();
  endtask : wait_irq
  task automatic s_reset();
    for (int k = 0; k < 8; k++) rd(16'(apgpi_pkg::ADDR_PORT_OUTPUT_DATA + 2 * k), k < 2 ? 8'h3f : 8'h00);
    rd(16'h0300, 8'h00);
    chk("pin", 8'(O_PIN), 8'h00);
  endtask : s_reset
  task automatic s_out();
    wr(apgpi_pkg::ADDR_PIN_DIRECTION, 8'h3f);
    wr(apgpi_pkg::ADDR_PORT_OUTPUT_DATA, 8'hea);
    wr(apgpi_pkg::ADDR_PULL_DEVICE_ENABLE, 8'h3f);
    cyc(2);
    chk("pin", 8'(O_PIN), 8'h2a);
    chk("oe", 8'(O_PIN_OE), 8'h3f);
    chk("pull", 8'(O_PULL_UP_EN | O_PULL_DOWN_EN), 8'h00);
    rd(apgpi_pkg::ADDR_PORT_OUTPUT_DATA, 8'h2a);
    I_DIG_IN_EN <= 6'h3f;
    I_ANALOG_SEL <= 6'h01;
    cyc(4);
    chk("oe", 8'(O_PIN_OE), 8'h3e);
    rd(apgpi_pkg::ADDR_PIN_LEVEL_INPUT, 8'h2a);
  endtask : s_out
  task automatic s_in();
    I_ANALOG_SEL <= 6'h00;
    drv_val <= 6'h15;
    wr(apgpi_pkg::ADDR_PIN_DIRECTION, 8'h00);
    cyc(4);
    rd(apgpi_pkg::ADDR_PORT_OUTPUT_DATA, 8'h15);
    wr(apgpi_pkg::ADDR_PIN_LEVEL_INPUT, 8'h00);
    rd(apgpi_pkg::ADDR_PIN_LEVEL_INPUT, 8'h15);
    I_DIG_IN_EN <= 6'h0f;
    cyc(1);
    rd(apgpi_pkg::ADDR_PIN_LEVEL_INPUT, 8'h35);
    wr(apgpi_pkg::ADDR_PULL_AND_EDGE_POLARITY, 8'h0f);
    drv_en <= 6'h00;
    I_DIG_IN_EN <= 6'h3f;
    cyc(4);
    chk("pullup", 8'(O_PULL_UP_EN), 8'h30);
    chk("pulldown", 8'(O_PULL_DOWN_EN), 8'h0f);
    rd(apgpi_pkg::ADDR_PIN_LEVEL_INPUT, 8'h30);
  endtask : s_in
  task automatic s_irq();
    drv_en <= 6'h3f;
    drv_val <= 6'h00;
    wr(apgpi_pkg::ADDR_PULL_AND_EDGE_POLARITY, 8'h01);
    wr(apgpi_pkg::ADDR_PIN_IRQ_ENABLE, 8'h01);
    cyc(4);
    wr(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h3f);
    rd(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h00);
    drv_val <= 6'h3f;
    wait_irq();
    rd(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h01);
    drv_val <= 6'h00;
    cyc(5);
    rd(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h3f);
    wr(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h00);
    rd(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h3f);
    wr(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h01);
    cyc(2);
    chk("irq", 8'(O_IRQ), 8'h00);
    I_STOP_MODE <= 1'b1;
    wr(apgpi_pkg::ADDR_PIN_IRQ_ENABLE, 8'h02);
    cyc(2);
    chk("irq", 8'(O_IRQ), 8'h01);
    chk("wake", 8'(O_OSC_WAKE_REQ), 8'h01);
    wr(apgpi_pkg::ADDR_PIN_IRQ_CLEAR, 8'h3e);
    cyc(2);
    chk("wake", 8'(O_OSC_WAKE_REQ), 8'h00);
    rd(apgpi_pkg::ADDR_PIN_IRQ_FLAG, 8'h00);
  endtask : s_irq
  initial begin
    repeat (16) @(posedge I_MCLK);
    I_RST_N <= 1'b1;
    s_reset();
    s_out();
    s_in();
    s_irq();
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
